// file: sfu_compare.sv
`timescale 1ns/1ps
`default_nettype none

module sfu_compare
  import sfu_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Compare request
  input wire logic compare_instruction,
  input wire sfu_pkg::sfu_cmp_mode_t cmp_mode,
  input wire sfu_pkg::sfu_word_t cmp_src1,
  input wire sfu_pkg::sfu_word_t cmp_src2,
  // Flags
  output logic less_than_flag,
  output logic less_or_equal_flag,
  output logic equal_flag,
  output logic greater_than_flag,
  output logic greater_or_equal_flag,
  output logic not_equal_flag
);

  // ----------------------------------------
  // Relation decode
  // ----------------------------------------
  wire logic lt_signed;
  wire logic lt_unsigned;
  wire logic rel_lt;
  wire logic rel_eq;

  assign lt_signed = $signed(cmp_src1) < $signed(cmp_src2);
  assign lt_unsigned = cmp_src1 < cmp_src2;
  assign rel_lt = (cmp_mode == SFU_CMP_SIGNED) ? lt_signed : lt_unsigned;
  assign rel_eq = cmp_src1 == cmp_src2;

  // ----------------------------------------
  // Flag hold, all six reload together
  // ----------------------------------------
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      less_than_flag <= 1'b0;
      less_or_equal_flag <= 1'b0;
      equal_flag <= 1'b0;
      greater_than_flag <= 1'b0;
      greater_or_equal_flag <= 1'b0;
      not_equal_flag <= 1'b0;
    end
    else if (compare_instruction)
    begin
      less_than_flag <= rel_lt;
      less_or_equal_flag <= rel_lt | rel_eq;
      equal_flag <= rel_eq;
      greater_than_flag <= ~rel_lt & ~rel_eq;
      greater_or_equal_flag <= ~rel_lt;
      not_equal_flag <= ~rel_eq;
    end
  end

endmodule

`default_nettype wire

// file: sfu_defs.svh
`ifndef SFU_DEFS_SVH
`define SFU_DEFS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SFU_ADDR_FLAGS_LO 8'h00
`define SFU_ADDR_FLAGS_HI 8'h04
`define SFU_ADDR_CTRL 8'h08
`define SFU_ADDR_IRQ_STATUS 8'h0C
`define SFU_ADDR_IRQ_MASK 8'h10

// ----------------------------------------
// Result flag positions, low word F0110..F011F
// ----------------------------------------
`define SFU_BIT_OP_ERROR 0
`define SFU_BIT_ZERO 1
`define SFU_BIT_CARRY 2
`define SFU_BIT_ALL_OFF 3
`define SFU_BIT_SHMEM_ERROR 4
`define SFU_BIT_OP_ERROR_LATCH 5

// ----------------------------------------
// Compare flag positions, high word F0120..F012F
// ----------------------------------------
`define SFU_BIT_LT 0
`define SFU_BIT_LE 1
`define SFU_BIT_EQ 2
`define SFU_BIT_GT 3
`define SFU_BIT_GE 4
`define SFU_BIT_NE 5

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define SFU_CTRL_SIGNED 0
`define SFU_CTRL_CLR_LATCH 1
`define SFU_CTRL_RESET 2'h0

// ----------------------------------------
// Interrupt event positions and reset values
// ----------------------------------------
`define SFU_EVT_OP_ERROR 0
`define SFU_EVT_CARRY 1
`define SFU_EVT_ALL_OFF 2
`define SFU_EVT_SHMEM_ERROR 3
`define SFU_EVT_COMPARE 4
`define SFU_EVT_COUNT 5
`define SFU_IRQ_STATUS_RESET 5'h00
`define SFU_IRQ_MASK_RESET 5'h00

`endif

// file: sfu_pkg.sv
package sfu_pkg;

  typedef logic [15:0] sfu_word_t;
  typedef logic [7:0] sfu_addr_t;
  typedef logic [31:0] sfu_data_t;
  typedef logic [4:0] sfu_evt_t;

  typedef enum logic
  {
    SFU_CMP_UNSIGNED,
    SFU_CMP_SIGNED
  } sfu_cmp_mode_t;

endpackage

// file: sfu_status_flags.sv
// Behaviour
// - The operation error flag at F0110 is on after an instruction that ends in an operation error.
// - The latched error copy at F0115 turns on with any operation error and stays on until cleared.
// - The zero flag at F0111 is on when the executed operation's result is zero.
// - The carry flag at F0112 is on when the executed operation carries out of its result width.
// - The flag at F0113 turns on when the all-outputs-off instruction executes.
// - The shared-memory error flag at F0114 turns on when a special-module common memory access fails.
// - A compare sets the less-than flag at F0120 when the first operand is below the second.
// - A compare sets the less-or-equal flag at F0121 when the first operand is not above the second.
// - A compare sets the equal flag at F0122 when both operands are equal.
// - A compare sets the greater-than flag at F0123 when the first operand is above the second.
// - A compare sets the greater-or-equal flag at F0124 when the first operand is not below the second.
// - A compare sets the not-equal flag at F0125 when the operands differ.
// - Bits F0116 to F011F and F0126 to F012F carry no function and read as zero.
`timescale 1ns/1ps
`default_nettype none
`include "sfu_defs.svh"

module sfu_status_flags
  import sfu_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Instruction completion
  input wire logic exec_done,
  input wire logic exec_error,
  input wire sfu_pkg::sfu_word_t exec_result,
  input wire logic exec_carry,
  // All outputs off instruction
  input wire logic all_off_exec,
  input wire logic all_off_release,
  // Special module common memory
  input wire logic shmem_done,
  input wire logic shmem_error,
  // Compare instruction
  input wire logic compare_instruction,
  input wire sfu_pkg::sfu_word_t cmp_src1,
  input wire sfu_pkg::sfu_word_t cmp_src2,
  // Register port
  input wire sfu_pkg::sfu_addr_t reg_addr,
  input wire sfu_pkg::sfu_data_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output sfu_pkg::sfu_data_t reg_rdata,
  // Flag devices
  output sfu_pkg::sfu_word_t flags_lo,
  output sfu_pkg::sfu_word_t flags_hi,
  // Interrupt
  output logic irq
);

  import sfu_pkg::*;

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic op_error_q;
  logic zero_q;
  logic carry_q;
  logic all_off_q;
  logic shmem_error_q;
  logic op_error_latch_q;
  logic cmp_signed_q;
  sfu_evt_t irq_status_q;
  sfu_evt_t irq_mask_q;
  sfu_data_t reg_rdata_q;
  logic irq_q;

  // ----------------------------------------
  // Compare flags
  // ----------------------------------------
  wire logic lt_flag;
  wire logic le_flag;
  wire logic eq_flag;
  wire logic gt_flag;
  wire logic ge_flag;
  wire logic ne_flag;
  wire sfu_cmp_mode_t cmp_mode;

  assign cmp_mode = cmp_signed_q ? SFU_CMP_SIGNED : SFU_CMP_UNSIGNED;

  sfu_compare u_compare
  (
    .clock(clock),
    .arst_n(arst_n),
    .compare_instruction(compare_instruction),
    .cmp_mode(cmp_mode),
    .cmp_src1(cmp_src1),
    .cmp_src2(cmp_src2),
    .less_than_flag(lt_flag),
    .less_or_equal_flag(le_flag),
    .equal_flag(eq_flag),
    .greater_than_flag(gt_flag),
    .greater_or_equal_flag(ge_flag),
    .not_equal_flag(ne_flag)
  );

  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  wire logic sel_flags_lo;
  wire logic sel_flags_hi;
  wire logic sel_ctrl;
  wire logic sel_irq_status;
  wire logic sel_irq_mask;
  wire logic wr_ctrl;
  wire logic wr_irq_status;
  wire logic wr_irq_mask;
  wire logic clr_latch;

  assign sel_flags_lo = reg_addr == `SFU_ADDR_FLAGS_LO;
  assign sel_flags_hi = reg_addr == `SFU_ADDR_FLAGS_HI;
  assign sel_ctrl = reg_addr == `SFU_ADDR_CTRL;
  assign sel_irq_status = reg_addr == `SFU_ADDR_IRQ_STATUS;
  assign sel_irq_mask = reg_addr == `SFU_ADDR_IRQ_MASK;
  assign wr_ctrl = reg_wr & sel_ctrl;
  assign wr_irq_status = reg_wr & sel_irq_status;
  assign wr_irq_mask = reg_wr & sel_irq_mask;
  // Clear bit is a strobe, never stored, so it reads zero
  assign clr_latch = wr_ctrl & reg_wdata[`SFU_CTRL_CLR_LATCH];

  // ----------------------------------------
  // Flag words, unused positions tied low
  // ----------------------------------------
  wire sfu_word_t flags_lo_w;
  wire sfu_word_t flags_hi_w;

  assign flags_lo_w = {10'h000, op_error_latch_q, shmem_error_q, all_off_q, carry_q, zero_q, op_error_q};
  assign flags_hi_w = {10'h000, ne_flag, ge_flag, gt_flag, eq_flag, le_flag, lt_flag};
  assign flags_lo = flags_lo_w;
  assign flags_hi = flags_hi_w;

  // ----------------------------------------
  // Next values of the result flags
  // ----------------------------------------
  wire logic zero_d;
  wire logic latch_d;
  wire logic all_off_d;
  wire logic shmem_error_d;

  assign zero_d = exec_result == 16'h0000;
  // Set beats clear so an error in the clearing cycle survives
  assign latch_d = (exec_done & exec_error) | (op_error_latch_q & ~clr_latch);
  // Release never wins over a fresh all-off instruction
  assign all_off_d = all_off_exec | (all_off_q & ~all_off_release);
  // A clean access clears the error, a failing one sets it
  assign shmem_error_d = shmem_error | (shmem_error_q & ~shmem_done);

  // ----------------------------------------
  // Result flags
  // ----------------------------------------
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      op_error_q <= 1'b0;
      zero_q <= 1'b0;
      carry_q <= 1'b0;
    end
    else if (exec_done)
    begin
      // Only a completed instruction reloads these, so a stall keeps the last result
      op_error_q <= exec_error;
      zero_q <= zero_d;
      carry_q <= exec_carry;
    end
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      op_error_latch_q <= 1'b0;
      all_off_q <= 1'b0;
      shmem_error_q <= 1'b0;
    end
    else
    begin
      op_error_latch_q <= latch_d;
      all_off_q <= all_off_d;
      shmem_error_q <= shmem_error_d;
    end
  end

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cmp_signed_q <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      cmp_signed_q <= reg_wdata[`SFU_CTRL_SIGNED];
    end
  end

  // ----------------------------------------
  // Interrupt events
  // ----------------------------------------
  wire sfu_evt_t evt;
  wire sfu_evt_t irq_status_d;

  assign evt[`SFU_EVT_OP_ERROR] = exec_done & exec_error;
  assign evt[`SFU_EVT_CARRY] = exec_done & exec_carry;
  assign evt[`SFU_EVT_ALL_OFF] = all_off_exec;
  assign evt[`SFU_EVT_SHMEM_ERROR] = shmem_error;
  assign evt[`SFU_EVT_COMPARE] = compare_instruction;

  genvar gi;
  generate
    for (gi = 0; gi < `SFU_EVT_COUNT; gi++)
    begin : g_evt
      // Write-one clear loses to an event in the same cycle
      assign irq_status_d[gi] = evt[gi] | (irq_status_q[gi] & ~(wr_irq_status & reg_wdata[gi]));
    end
  endgenerate

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      irq_status_q <= `SFU_IRQ_STATUS_RESET;
    end
    else
    begin
      irq_status_q <= irq_status_d;
    end
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      // Mask only gates the interrupt; status still records masked events
      irq_mask_q <= `SFU_IRQ_MASK_RESET;
    end
    else if (wr_irq_mask)
    begin
      irq_mask_q <= reg_wdata[`SFU_EVT_COUNT-1:0];
    end
  end

  // Registered, so irq trails the status bit by one cycle
  wire logic irq_d;

  assign irq_d = |(irq_status_q & irq_mask_q);

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= irq_d;
    end
  end

  assign irq = irq_q;

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  wire sfu_data_t rd_ctrl;
  wire sfu_data_t rd_mux;

  assign rd_ctrl = {31'h00000000, cmp_signed_q};
  // Unmapped offsets fall through to zero
  assign rd_mux = sel_flags_lo ? {16'h0000, flags_lo_w} :
                  sel_flags_hi ? {16'h0000, flags_hi_w} :
                  sel_ctrl ? rd_ctrl :
                  sel_irq_status ? {27'h0000000, irq_status_q} :
                  sel_irq_mask ? {27'h0000000, irq_mask_q} :
                  32'h00000000;

  // Data stand only in the cycle after the strobe
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      reg_rdata_q <= 32'h00000000;
    end
    else if (reg_rd)
    begin
      reg_rdata_q <= rd_mux;
    end
    else
    begin
      reg_rdata_q <= 32'h00000000;
    end
  end

  assign reg_rdata = reg_rdata_q;

endmodule

`default_nettype wire

// file: sfu_status_flags_properties.sv
`timescale 1ns/1ps
`default_nettype none

module sfu_flags_chk
  import sfu_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Instruction inputs
  input wire logic exec_done,
  input wire logic exec_error,
  input wire sfu_pkg::sfu_word_t exec_result,
  input wire logic exec_carry,
  input wire logic all_off_exec,
  input wire logic shmem_error,
  input wire logic compare_instruction,
  input wire sfu_pkg::sfu_word_t cmp_src1,
  input wire sfu_pkg::sfu_word_t cmp_src2,
  // Flag devices
  input wire sfu_pkg::sfu_word_t flags_lo,
  input wire sfu_pkg::sfu_word_t flags_hi,
  // Register port
  input wire logic reg_rd,
  input wire sfu_pkg::sfu_data_t reg_rdata
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!arst_n);

  // ----------------------------------------
  // Result flags
  // ----------------------------------------
  a_error_flag: assert property (exec_done |=> flags_lo[0] == $past(exec_error))
    else $error("error flag not loaded");
  a_error_latch: assert property (exec_done && exec_error |=> flags_lo[5])
    else $error("error latch not set");
  a_zero_flag: assert property (exec_done |=> flags_lo[1] == ($past(exec_result) == 16'h0))
    else $error("zero flag wrong");
  a_carry_flag: assert property (exec_done |=> flags_lo[2] == $past(exec_carry))
    else $error("carry flag wrong");
  a_all_off_set: assert property (all_off_exec |=> flags_lo[3])
    else $error("all off flag not set");
  a_shmem_set: assert property (shmem_error |=> flags_lo[4])
    else $error("shared memory flag not set");
  a_unused_zero: assert property (flags_lo[15:6] == 10'h0 && flags_hi[15:6] == 10'h0)
    else $error("unused flag bit set");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h00000000)
    else $error("read data not cleared");

  // ----------------------------------------
  // Compare flags
  // ----------------------------------------
  a_compare_hold: assert property (!compare_instruction |=> $stable(flags_hi))
    else $error("compare flags moved");
  a_compare_equal: assert property (compare_instruction |=>
    flags_hi[2] == ($past(cmp_src1) == $past(cmp_src2)) && flags_hi[5] != flags_hi[2])
    else $error("equal flags wrong");
  a_compare_order: assert property (compare_instruction |=>
    flags_hi[1] == (flags_hi[0] | flags_hi[2]) && flags_hi[4] == (flags_hi[3] | flags_hi[2])
    && !(flags_hi[0] && flags_hi[3]))
    else $error("order flags inconsistent");
endmodule

bind sfu_status_flags sfu_flags_chk i_sfu_flags_chk (.clock, .arst_n, .exec_done, .exec_error, .exec_result,
  .exec_carry, .all_off_exec, .shmem_error, .compare_instruction, .cmp_src1, .cmp_src2, .flags_lo, .flags_hi,
  .reg_rd, .reg_rdata);

`default_nettype wire

// file: status_flag_unit_tb.sv
`timescale 1ns/1ps
`default_nettype none

module status_flag_unit_tb
  import sfu_pkg::*;
;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic exec_done = 1'b0, exec_error = 1'b0, exec_carry = 1'b0, all_off_exec = 1'b0, all_off_release = 1'b0;
  logic shmem_done = 1'b0, shmem_error = 1'b0, compare_instruction = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, irq;
  sfu_word_t exec_result = 16'h0, cmp_src1 = 16'h0, cmp_src2 = 16'h0, flags_lo, flags_hi;
  sfu_addr_t reg_addr = 8'h0;
  sfu_data_t reg_wdata = 32'h0, reg_rdata;
  integer n_errors = 0, cmp_count = 0, seed = 32'hC29B, r, d, a, b, ph;
  integer m_lo = 0, m_hi = 0, m_st = 0, m_mask = 0, m_sgn = 0, m_irq = 0;

  always #12.5 clock = ~clock;

  sfu_status_flags i_sfu_status_flags (.clock, .arst_n, .exec_done, .exec_error, .exec_result, .exec_carry,
    .all_off_exec, .all_off_release, .shmem_done, .shmem_error, .compare_instruction, .cmp_src1, .cmp_src2,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .flags_lo, .flags_hi, .irq);

  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task automatic chk(input string n, input sfu_data_t e, input sfu_data_t g);
    cmp_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input sfu_addr_t ad, input sfu_data_t v);
    reg_addr <= ad;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    // Idle edge, so back to back writes never drive the strobe twice at once
    @(posedge clock);
  endtask

  task automatic rd(input sfu_addr_t ad, input sfu_data_t e);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", e, reg_rdata);
    @(posedge clock);
  endtask

  // Last offset is unmapped and must read zero
  task automatic regs();
    sfu_data_t e [6];
    e = '{m_lo, m_hi, m_sgn, m_st, m_mask, 0};
    for (int i = 0; i < 6; i++)
      rd(8'(4 * i), e[i]);
  endtask

  // One instruction cycle; checks what the previous cycle caused
  task automatic step(input bit quiet);
    logic ed, ee, ec, ax, ar, sd, se, ci;
    sfu_word_t res, s1, s2;
    r = quiet ? 0 : $random(seed);
    {ed, ee, ec, ax, ar} = {r[0], r[1] & r[2], r[3], r[4] & r[5] & r[6], r[7] & r[8]};
    {sd, se, ci} = {r[9], r[9] & r[10] & r[11], r[12]};
    res = (r[13] & r[14]) ? 16'h0 : 16'($random(seed));
    s1 = 16'($random(seed));
    s2 = r[15] ? s1 : 16'($random(seed));
    {exec_done, exec_error, exec_carry, all_off_exec, all_off_release} <= {ed, ee, ec, ax, ar};
    {shmem_done, shmem_error, compare_instruction} <= {sd, se, ci};
    {exec_result, cmp_src1, cmp_src2} <= {res, s1, s2};
    #1;
    chk("flags_lo", m_lo, flags_lo);
    chk("flags_hi", m_hi, flags_hi);
    chk("irq", m_irq, irq);
    m_irq = (m_st & m_mask) != 0;
    if (ed)
      m_lo = {m_lo[5] | ee, m_lo[4:3], ec, res == 16'h0, ee};
    m_lo[3] = ax | (m_lo[3] & !ar);
    m_lo[4] = se | (m_lo[4] & !sd);
    a = (m_sgn != 0 && s1[15]) ? s1 - 65536 : s1;
    b = (m_sgn != 0 && s2[15]) ? s2 - 65536 : s2;
    if (ci)
      m_hi = {a != b, a >= b, a > b, a == b, a <= b, a < b};
    m_st = m_st | {ci, se, ax, ed & ec, ed & ee};
    @(posedge clock);
  endtask

  task automatic print_verdict();
    $display("Compares %0d, errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  // Phases cover both compare modes; the latch is cleared in the last two
  initial
  begin
    repeat (10) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    regs();
    for (ph = 0; ph < 4; ph++)
    begin
      d = $random(seed);
      wr(8'h10, d);
      m_mask = d & 32'h1F;
      wr(8'h08, {ph[1], ph[0]});
      m_sgn = ph[0];
      if (ph[1])
        m_lo[5] = 0;
      wr(8'h00, 32'hFFFF);
      m_irq = (m_st & m_mask) != 0;
      regs();
      repeat (150) step(1'b0);
      step(1'b1);
      regs();
      d = $random(seed);
      wr(8'h0C, d);
      m_st = m_st & ~d;
      m_irq = (m_st & m_mask) != 0;
      regs();
      $display("Phase %0d done, errors %0d", ph, n_errors);
    end
    print_verdict();
  end

  // Hang guard
  initial
  begin
    #1000000;
    n_errors++;
    print_verdict();
  end
endmodule

`default_nettype wire
